// file: sdb_config.v
// Shadow doorbell buffer configuration command handler with an AXI4-Lite register slave.
//
// Implementation choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "sdb_consts.vh"
// Behaviour
// - Only the two buffer pointers and the three capability flags are used; other command fields are ignored.
// - Namespace-specific, metadata or scatter-gather requests are rejected.
// - Reset discards both addresses and leaves the mode unconfigured.
// - Entry span, stride bytes times largest queue plus one, must fit a page.
// - Entries are four bytes, spaced by four shifted by the stride; admin tail first.
// - Queue y tail sits at entry 2y, its head at entry 2y plus one.
// - Entries span queue pairs up to the larger allocated queue count.
// - Mirror offsets add to the first pointer, event index to the second.
// - Event index base comes page-aligned from the second pointer.
// - Each command finishes with exactly one completion carrying its status.
// - An invalid address completes with invalid-field status and adopts nothing.
module sdb_config #(
    parameter QW = 12
) (
    input wire aclk,
    input wire aresetn,
    input wire aclk_en,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    output wire [63:0] mirror_base,
    output wire [63:0] event_index_base,
    output wire buffers_valid,
    output wire irq
);
    localparam ST_IDLE = 2'b00;
    localparam ST_CHECK = 2'b01;
    localparam ST_DONE = 2'b10;

    reg [1:0] state_reg;
    reg [31:0] cmd_flags_reg;
    reg [63:0] mirror_ptr_reg;
    reg [63:0] event_ptr_reg;
    reg [31:0] geom_reg;
    reg [63:0] mirror_base_reg;
    reg [63:0] event_base_reg;
    reg valid_reg;
    reg [7:0] cpl_status_reg;
    reg cpl_count_reg;
    reg [QW:0] lookup_reg;
    reg [1:0] irq_stat_reg;
    reg [1:0] irq_en_reg;
    reg start_reg;

    reg aw_full_reg;
    reg [7:0] aw_addr_reg;
    reg w_full_reg;
    reg [31:0] w_data_reg;
    reg [3:0] w_strb_reg;
    reg bvalid_reg;
    reg [1:0] bresp_reg;
    reg rvalid_reg;
    reg [31:0] rdata_reg;
    reg [1:0] rresp_reg;

    wire [31:0] entry_offset;
    wire [QW-1:0] max_queue;
    wire span_fits;
    wire [63:0] page_mask;
    wire mirror_ok;
    wire event_ok;
    wire cmd_ok;
    wire fields_ok;
    wire do_write;
    wire do_read;
    wire [1:0] irq_set;
    reg [31:0] rd_mux;
    reg rd_hit;
    reg wr_hit;
    wire [5:0] page_shift;
    wire mirror_aligned;
    wire mirror_nonzero;
    wire event_aligned;
    wire event_nonzero;
    wire flag_nsid;
    wire flag_meta;
    wire flag_sgl;
    wire cmd_busy;
    wire check_phase;
    wire clr_strobe;

    sdb_offset_calc #(.QW(QW)) u_calc (
        .doorbell_stride(geom_reg[`SDB_GEOM_STRIDE_LSB +: 4]),
        .memory_page_size(geom_reg[`SDB_GEOM_MPS_LSB +: 4]),
        .allocated_sq_count(geom_reg[`SDB_GEOM_SQ_LSB +: QW]),
        .allocated_cq_count(geom_reg[`SDB_GEOM_CQ_LSB +: QW]),
        .entry_index(lookup_reg),
        .entry_offset(entry_offset),
        .max_queue(max_queue),
        .span_fits(span_fits)
    );

    // Low page bits must be zero; the page is 4 KiB shifted by the page size setting.
    assign page_shift = `SDB_PAGE_SHIFT_BASE + {2'b00, geom_reg[`SDB_GEOM_MPS_LSB +: 4]};
    assign page_mask = ~(64'hffffffffffffffff << page_shift);
    // A zero pointer is refused as well, since it can never name a usable host page.
    assign mirror_aligned = ((mirror_ptr_reg & page_mask) == 64'h0000000000000000);
    assign mirror_nonzero = (mirror_ptr_reg != 64'h0000000000000000);
    assign mirror_ok = mirror_aligned && mirror_nonzero;
    assign event_aligned = ((event_ptr_reg & page_mask) == 64'h0000000000000000);
    assign event_nonzero = (event_ptr_reg != 64'h0000000000000000);
    assign event_ok = event_aligned && event_nonzero;
    // Only the three capability flags are examined; other command words are never interpreted.
    assign flag_nsid = cmd_flags_reg[`SDB_CMD_NSID_BIT];
    assign flag_meta = cmd_flags_reg[`SDB_CMD_META_BIT];
    assign flag_sgl = cmd_flags_reg[`SDB_CMD_SGL_BIT];
    assign fields_ok = !flag_nsid && !flag_meta && !flag_sgl;
    assign cmd_ok = mirror_ok && event_ok && fields_ok && span_fits;
    assign cmd_busy = (state_reg != ST_IDLE);
    assign check_phase = (state_reg == ST_CHECK);
    assign clr_strobe = do_write && (aw_addr_reg == `SDB_OFF_IRQ_CLR) && (w_strb_reg == 4'hf);

    assign do_write = aw_full_reg && w_full_reg && !bvalid_reg;
    assign do_read = s_axi_arvalid && !rvalid_reg;

    always @* begin
        wr_hit = 1'b1;
        case (aw_addr_reg)
            `SDB_OFF_CTRL,
            `SDB_OFF_CMD_LO,
            `SDB_OFF_CMD_HI,
            `SDB_OFF_MIR_LO,
            `SDB_OFF_MIR_HI,
            `SDB_OFF_EVT_LO,
            `SDB_OFF_EVT_HI,
            `SDB_OFF_GEOM,
            `SDB_OFF_LOOKUP,
            `SDB_OFF_IRQ_EN,
            `SDB_OFF_IRQ_CLR: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always @* begin
        rd_hit = 1'b1;
        rd_mux = 32'h00000000;
        case (s_axi_araddr)
            `SDB_OFF_CTRL: rd_mux = {30'h00000000, cmd_busy, start_reg};
            `SDB_OFF_CMD_LO: rd_mux = cmd_flags_reg;
            `SDB_OFF_CMD_HI: rd_mux = 32'h00000000;
            `SDB_OFF_MIR_LO: rd_mux = mirror_ptr_reg[31:0];
            `SDB_OFF_MIR_HI: rd_mux = mirror_ptr_reg[63:32];
            `SDB_OFF_EVT_LO: rd_mux = event_ptr_reg[31:0];
            `SDB_OFF_EVT_HI: rd_mux = event_ptr_reg[63:32];
            `SDB_OFF_GEOM: rd_mux = geom_reg;
            `SDB_OFF_STATUS: rd_mux = {31'h00000000, valid_reg};
            `SDB_OFF_CPL: rd_mux = {23'h000000, cpl_count_reg, cpl_status_reg};
            `SDB_OFF_LOOKUP: rd_mux = {{(31-QW){1'b0}}, lookup_reg};
            // Lookup offsets are useful only once buffers are adopted, so they read zero before then.
            `SDB_OFF_ADDR_LO: rd_mux = valid_reg ? entry_offset : 32'h00000000;
            `SDB_OFF_ADDR_HI: rd_mux = {{(32-QW){1'b0}}, max_queue};
            `SDB_OFF_IRQ_STAT: rd_mux = {30'h00000000, irq_stat_reg};
            `SDB_OFF_IRQ_EN: rd_mux = {30'h00000000, irq_en_reg};
            `SDB_OFF_IRQ_CLR: rd_mux = 32'h00000000;
            default: rd_hit = 1'b0;
        endcase
    end

    assign irq_set = check_phase ? {~cmd_ok, 1'b1} : 2'b00;

    // Address and data are buffered apart, so the master may offer them in either order.
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
        end else if (aclk_en) begin
            if (do_write) begin
                aw_full_reg <= 1'b0;
            end else if (s_axi_awvalid && !aw_full_reg) begin
                aw_full_reg <= 1'b1;
                aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            w_full_reg <= 1'b0;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
        end else if (aclk_en) begin
            if (do_write) begin
                w_full_reg <= 1'b0;
            end else if (s_axi_wvalid && !w_full_reg) begin
                w_full_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
        end
    end

    // The response stands until the master takes it; the next write waits for that.
    always @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= `SDB_RESP_OKAY;
        end else if (aclk_en) begin
            if (do_write) begin
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_hit ? `SDB_RESP_OKAY : `SDB_RESP_SLVERR;
            end else if (bvalid_reg && s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // Read data is captured with the address, so later register changes cannot alter a pending answer.
    always @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= `SDB_RESP_OKAY;
        end else if (aclk_en) begin
            if (do_read) begin
                rvalid_reg <= 1'b1;
                rdata_reg <= rd_mux;
                rresp_reg <= rd_hit ? `SDB_RESP_OKAY : `SDB_RESP_SLVERR;
            end else if (rvalid_reg && s_axi_rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    // Software registers and the start request.
    always @(posedge aclk) begin
        if (!aresetn) begin
            cmd_flags_reg <= 32'h00000000;
            mirror_ptr_reg <= 64'h0000000000000000;
            event_ptr_reg <= 64'h0000000000000000;
            geom_reg <= 32'h00000000;
            lookup_reg <= {(QW+1){1'b0}};
            irq_en_reg <= 2'b00;
            start_reg <= 1'b0;
        end else if (aclk_en) begin
            if (do_write && wr_hit && w_strb_reg == 4'hf) begin
                case (aw_addr_reg)
                    `SDB_OFF_CTRL: start_reg <= w_data_reg[`SDB_CTRL_START_BIT] | start_reg;
                    `SDB_OFF_CMD_LO: cmd_flags_reg <= w_data_reg;
                    `SDB_OFF_MIR_LO: mirror_ptr_reg[31:0] <= w_data_reg;
                    `SDB_OFF_MIR_HI: mirror_ptr_reg[63:32] <= w_data_reg;
                    `SDB_OFF_EVT_LO: event_ptr_reg[31:0] <= w_data_reg;
                    `SDB_OFF_EVT_HI: event_ptr_reg[63:32] <= w_data_reg;
                    `SDB_OFF_GEOM: geom_reg <= w_data_reg;
                    `SDB_OFF_LOOKUP: lookup_reg <= w_data_reg[QW:0];
                    `SDB_OFF_IRQ_EN: irq_en_reg <= w_data_reg[1:0];
                    default: start_reg <= start_reg;
                endcase
            end
            // The start request stays pending until the engine has posted its completion.
            if (state_reg == ST_DONE) begin
                start_reg <= 1'b0;
            end
        end
    end

    // Command engine: one cycle to check the request and post its completion, one to clear the start request.
    always @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= ST_IDLE;
        end else if (aclk_en) begin
            case (state_reg)
                ST_IDLE: begin
                    if (start_reg) begin
                        state_reg <= ST_CHECK;
                    end
                end
                ST_CHECK: state_reg <= ST_DONE;
                ST_DONE: state_reg <= ST_IDLE;
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // Bases move only on a passing check, so a refused command leaves earlier buffers in place.
    always @(posedge aclk) begin
        if (!aresetn) begin
            mirror_base_reg <= 64'h0000000000000000;
            event_base_reg <= 64'h0000000000000000;
            valid_reg <= 1'b0;
        end else if (aclk_en) begin
            if (check_phase && cmd_ok) begin
                mirror_base_reg <= mirror_ptr_reg;
                event_base_reg <= event_ptr_reg;
                valid_reg <= 1'b1;
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            cpl_status_reg <= `SDB_STATUS_SUCCESS;
            cpl_count_reg <= 1'b0;
        end else if (aclk_en) begin
            if (state_reg == ST_IDLE && start_reg) begin
                cpl_count_reg <= 1'b0;
            end else if (check_phase) begin
                cpl_status_reg <= cmd_ok ? `SDB_STATUS_SUCCESS : `SDB_STATUS_INVALID_FIELD;
                cpl_count_reg <= 1'b1;
            end
        end
    end

    // A new event wins over a clear written in the same cycle.
    always @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_reg <= 2'b00;
        end else if (aclk_en) begin
            if (clr_strobe) begin
                irq_stat_reg <= (irq_stat_reg & ~w_data_reg[1:0]) | irq_set;
            end else begin
                irq_stat_reg <= irq_stat_reg | irq_set;
            end
        end
    end

    // Ready stays low while the clock enable freezes the slave, so no transfer is lost.
    assign s_axi_awready = !aw_full_reg && aclk_en;
    assign s_axi_wready = !w_full_reg && aclk_en;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = !rvalid_reg && aclk_en;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign mirror_base = mirror_base_reg;
    assign event_index_base = event_base_reg;
    assign buffers_valid = valid_reg;
    assign irq = |(irq_stat_reg & irq_en_reg);
endmodule

// file: sdb_config_chk.sv
// Concurrent port checks for the doorbell mirror configuration handler.
`timescale 1ns/1ps
module sdb_config_chk (
    input wire aclk,
    input wire aresetn,
    input wire aclk_en,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [63:0] mirror_base,
    input wire [63:0] event_index_base,
    input wire buffers_valid
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence wr_taken;
        aclk_en && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        aclk_en && s_axi_arvalid && s_axi_arready;
    endsequence
    // The reset check runs without the disable, since it is about the reset itself.
    rst_clear_a: assert property (disable iff (1'b0) !aresetn && aclk_en |=>
        !buffers_valid && mirror_base == 64'h0 && !s_axi_bvalid) else $error("state kept over reset");
    valid_drop_a: assert property ($fell(buffers_valid) |-> !$past(aresetn))
        else $error("valid flag fell without reset");
    zero_base_a: assert property (!buffers_valid |-> mirror_base == 64'h0 && event_index_base == 64'h0)
        else $error("bases adopted without valid flag");
    page_align_a: assert property (buffers_valid |-> mirror_base[11:0] == 12'h0 &&
        event_index_base[11:0] == 12'h0 && mirror_base != 64'h0) else $error("bad base adopted");
    base_move_a: assert property ($changed(mirror_base) || $changed(event_index_base) |->
        buffers_valid || !$past(aresetn)) else $error("base moved while unconfigured");
    wr_resp_a: assert property (wr_taken |-> ##[1:2] s_axi_bvalid) else $error("no write response");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
    rd_resp_a: assert property (rd_taken |=> s_axi_rvalid) else $error("no read response");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer not held");
endmodule
bind sdb_config sdb_config_chk i_chk (.aclk, .aresetn, .aclk_en, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rready, .mirror_base, .event_index_base, .buffers_valid);

// file: sdb_consts.vh
// Constants for the shadow doorbell buffer configuration block.
`ifndef SDB_CONSTS_VH
`define SDB_CONSTS_VH
`define SDB_OFF_CTRL 8'h00
`define SDB_OFF_CMD_LO 8'h04
`define SDB_OFF_CMD_HI 8'h08
`define SDB_OFF_MIR_LO 8'h0c
`define SDB_OFF_MIR_HI 8'h10
`define SDB_OFF_EVT_LO 8'h14
`define SDB_OFF_EVT_HI 8'h18
`define SDB_OFF_GEOM 8'h1c
`define SDB_OFF_STATUS 8'h20
`define SDB_OFF_CPL 8'h24
`define SDB_OFF_LOOKUP 8'h28
`define SDB_OFF_ADDR_LO 8'h2c
`define SDB_OFF_ADDR_HI 8'h30
`define SDB_OFF_IRQ_STAT 8'h34
`define SDB_OFF_IRQ_EN 8'h38
`define SDB_OFF_IRQ_CLR 8'h3c
`define SDB_CTRL_START_BIT 0
`define SDB_CMD_NSID_BIT 0
`define SDB_CMD_META_BIT 1
`define SDB_CMD_SGL_BIT 2
`define SDB_GEOM_STRIDE_LSB 0
`define SDB_GEOM_MPS_LSB 4
`define SDB_GEOM_SQ_LSB 8
`define SDB_GEOM_CQ_LSB 20
`define SDB_STATUS_SUCCESS 8'h00
`define SDB_STATUS_INVALID_FIELD 8'h02
`define SDB_ENTRY_BYTES 32'h00000004
`define SDB_PAGE_SHIFT_BASE 6'h0c
`define SDB_RESP_OKAY 2'b00
`define SDB_RESP_SLVERR 2'b10
`define SDB_IRQ_DONE_BIT 0
`define SDB_IRQ_ERR_BIT 1
`endif

// file: sdb_host.sv
// Host software model that issues register accesses over the AXI4-Lite bus.
`timescale 1ns/1ps
module sdb_host (
    input wire aclk,
    output reg [7:0] s_axi_awaddr,
    output reg s_axi_awvalid,
    input wire s_axi_awready,
    output reg [31:0] s_axi_wdata,
    output reg s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    output reg s_axi_bready,
    output reg [7:0] s_axi_araddr,
    output reg s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    output reg s_axi_rready
);
    // A slow host holds bready low for dly cycles so the response must wait.
    integer dly = 0;
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = 0;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} = 0;
    end
    task wr(input [7:0] a, input [31:0] v, output [1:0] r);
        reg ad, wd;
        begin
            ad = 0;
            wd = 0;
            @(posedge aclk);
            s_axi_awaddr <= a;
            s_axi_awvalid <= 1;
            s_axi_wdata <= v;
            s_axi_wvalid <= 1;
            while (!ad || !wd) begin
                @(posedge aclk);
                if (!ad && s_axi_awready) begin
                    ad = 1;
                    s_axi_awvalid <= 0;
                end
                if (!wd && s_axi_wready) begin
                    wd = 1;
                    s_axi_wvalid <= 0;
                end
            end
            repeat (dly) @(posedge aclk);
            s_axi_bready <= 1;
            do @(posedge aclk); while (!s_axi_bvalid);
            r = s_axi_bresp;
            s_axi_bready <= 0;
        end
    endtask
    task rd(input [7:0] a, output [31:0] d, output [1:0] r);
        begin
            @(posedge aclk);
            s_axi_araddr <= a;
            s_axi_arvalid <= 1;
            s_axi_rready <= 1;
            do @(posedge aclk); while (!s_axi_arready);
            s_axi_arvalid <= 0;
            do @(posedge aclk); while (!s_axi_rvalid);
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 0;
        end
    endtask
endmodule

// file: sdb_offset_calc.v
// Entry offset and span arithmetic for the mirror and event index pages.
`timescale 1ns/1ps
`include "sdb_consts.vh"
module sdb_offset_calc #(
    parameter QW = 12
) (
    input wire [3:0] doorbell_stride,
    input wire [3:0] memory_page_size,
    input wire [QW-1:0] allocated_sq_count,
    input wire [QW-1:0] allocated_cq_count,
    input wire [QW:0] entry_index,
    output wire [31:0] entry_offset,
    output wire [QW-1:0] max_queue,
    output wire span_fits
);
    wire [31:0] stride_bytes;
    wire [63:0] span;
    wire [63:0] page_bytes;
    wire [5:0] page_shift;

    assign stride_bytes = `SDB_ENTRY_BYTES << doorbell_stride;
    assign max_queue = (allocated_sq_count > allocated_cq_count) ? allocated_sq_count : allocated_cq_count;
    assign entry_offset = stride_bytes * {{(31-QW){1'b0}}, entry_index};
    assign span = {32'h00000000, stride_bytes} * {{(64-QW){1'b0}}, max_queue} + {32'h00000000, stride_bytes};
    assign page_shift = `SDB_PAGE_SHIFT_BASE + {2'b00, memory_page_size};
    assign page_bytes = 64'h0000000000000001 << page_shift;
    assign span_fits = (span <= page_bytes);
endmodule

// file: tb_shadow_doorbell_buffer_config.sv
// Self-checking bench for the doorbell mirror configuration handler.
`timescale 1ns/1ps
`include "sdb_consts.vh"
module tb_shadow_doorbell_buffer_config;
    reg aclk, aresetn, aclk_en;
    wire [7:0] s_axi_awaddr, s_axi_araddr;
    wire [31:0] s_axi_wdata, s_axi_rdata;
    wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    wire s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, buffers_valid, irq;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [63:0] mirror_base, event_index_base;
    integer miscompares = 0, n_checks = 0, seed = 32'hb77e, i, k, cnt;
    reg [63:0] m, e, mv, ev, pm;
    reg [31:0] d, fl;
    reg [1:0] r;
    reg [3:0] st, ps;
    reg [11:0] sq, cq, mx;
    reg ok, vld;
    sdb_config i_dut (.aclk, .aresetn, .aclk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .mirror_base, .event_index_base, .buffers_valid, .irq);
    sdb_host i_host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    task chk(input [127:0] got, input [127:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task tally_and_finish;
        begin
            $display("checks %0d, mismatches %0d", n_checks, miscompares);
            if (miscompares == 0 && n_checks > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    task wr(input [7:0] a, input [31:0] v);
        begin
            i_host.wr(a, v, r);
            chk(r, `SDB_RESP_OKAY);
        end
    endtask
    task rd(input [7:0] a, input [31:0] mask, input [31:0] exp);
        begin
            i_host.rd(a, d, r);
            chk({r, d & mask}, {`SDB_RESP_OKAY, exp});
        end
    endtask
    initial begin
        aclk = 0;
        forever #5 aclk = ~aclk;
    end
    initial begin
        repeat (30000) @(posedge aclk);
        miscompares = miscompares + 1;
        tally_and_finish;
    end
    initial begin
        aresetn = 0;
        aclk_en = 1;
        {vld, mv, ev} = 0;
        repeat (3) @(posedge aclk);
        aresetn <= 1;
        rd(`SDB_OFF_STATUS, 1, 0);
        i_host.rd(8'h40, d, r);
        chk({r, d}, {`SDB_RESP_SLVERR, 32'h0});
        for (i = 0; i < 24; i = i + 1) begin
            st = $random(seed) & 3;
            ps = $random(seed) & 3;
            sq = $random(seed) & 63;
            cq = (i % 5 == 4) ? 12'hfff : $random(seed) & 63;
            fl = (i % 4 == 1) ? (32'h1 << (i % 3)) : ($random(seed) & ~32'h7);
            pm = (64'h1 << (12 + ps)) - 1;
            m = {$random(seed), $random(seed)} & ~pm;
            e = {$random(seed), $random(seed)} & ~pm;
            if (i % 4 == 2) m = m | 64'h4;
            if (i % 4 == 3) e = 0;
            mx = sq > cq ? sq : cq;
            ok = fl[2:0] == 0 && m != 0 && e != 0 && !(m & pm) && !(e & pm) && (64'h4 << st) * (mx + 1) <= pm + 1;
            i_host.dly = i % 3;
            wr(`SDB_OFF_IRQ_EN, (i % 3) ? 3 : 0);
            wr(`SDB_OFF_MIR_LO, m[31:0]);
            wr(`SDB_OFF_MIR_HI, m[63:32]);
            wr(`SDB_OFF_EVT_LO, e[31:0]);
            wr(`SDB_OFF_EVT_HI, e[63:32]);
            wr(`SDB_OFF_CMD_LO, fl);
            wr(`SDB_OFF_CMD_HI, $random(seed));
            wr(`SDB_OFF_GEOM, {cq, sq, ps, st});
            wr(`SDB_OFF_CTRL, 1);
            cnt = 0;
            do begin
                i_host.rd(`SDB_OFF_CTRL, d, r);
                cnt = cnt + 1;
            end while (d[1:0] != 2'b00 && cnt < 20);
            chk(d[1:0], 2'b00);
            if (ok) {vld, mv, ev} = {1'b1, m, e};
            rd(`SDB_OFF_CPL, 32'h1ff, {1'b1, ok ? `SDB_STATUS_SUCCESS : `SDB_STATUS_INVALID_FIELD});
            rd(`SDB_OFF_STATUS, 1, vld);
            chk({buffers_valid, mirror_base}, {vld, mv});
            chk(event_index_base, ev);
            rd(`SDB_OFF_IRQ_STAT, 3, ok ? 1 : 3);
            chk(irq, (i % 3) != 0);
            rd(`SDB_OFF_ADDR_HI, 32'hfff, mx);
            for (k = 0; k < 2; k = k + 1) begin
                wr(`SDB_OFF_LOOKUP, 2 * sq + k);
                rd(`SDB_OFF_ADDR_LO, 32'hffffffff, vld ? (2 * sq + k) * (32'h4 << st) : 0);
            end
            wr(`SDB_OFF_IRQ_CLR, 3);
            chk(irq, 0);
        end
        @(posedge aclk);
        aresetn <= 0;
        @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        chk({buffers_valid, mirror_base, s_axi_bvalid}, 0);
        rd(`SDB_OFF_STATUS, 1, 0);
        rd(`SDB_OFF_ADDR_LO, 32'hffffffff, 0);
        tally_and_finish;
    end
endmodule
